// ### core/gls_ctrl.sv
// Safety output, guard locking and actuator learning control
`timescale 1ns/1ps
module gls_ctrl
	import gls_pkg::*;
#(
	parameter int TICK_CYC  = TICK_CYCLES,
	parameter int WAIT_TK   = LEARN_WAIT_TICKS,
	parameter int CONFIRM_TK = CONFIRM_TICKS
) (
	// Clock and reset (reset is the power cycle)
	input  wire logic            i_sys_clk,
	input  wire logic            i_reset,
	// Nonvolatile store erase, variant strap
	input  wire logic            i_nv_clear,
	input  wire logic            i_fully_coded,
	// Actuator detection
	input  wire logic            i_act_present,
	input  wire logic [ID_W-1:0] i_act_id,
	input  wire logic            i_act_single,
	// Lock request and magnet monitoring
	input  wire logic            i_lock_request_input,
	input  wire logic            i_hold_ok,
	input  wire logic            i_wind_open,
	input  wire logic            i_wind_short,
	input  wire logic            i_supply_low,
	// Safety outputs and magnet drive
	output logic                 o_safe_out_1,
	output logic                 o_safe_out_2,
	output logic                 o_magnet_on,
	// Indicators and learning status
	output logic                 o_lock_green,
	output logic                 o_lock_red,
	output logic                 o_gate_yellow,
	output logic                 o_learn_refused,
	output logic [3:0]           o_learn_left
);
	// ----------------------------------------------------------------
	// Millisecond tick and flash phase
	// ----------------------------------------------------------------
	logic [17:0]     tick_cnt_reg;
	logic            tick_reg;
	logic [FL_W-1:0] fl_cnt_reg;

	always_ff @(posedge i_sys_clk) begin
		if (i_reset || tick_cnt_reg == 18'(TICK_CYC - 1)) begin
			tick_cnt_reg <= '0;
		end else begin
			tick_cnt_reg <= tick_cnt_reg + 18'h1;
		end
		tick_reg <= !i_reset && tick_cnt_reg == 18'(TICK_CYC - 1);
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_reset || (tick_reg && fl_cnt_reg == FL_W'(SLOW_PERIOD_MS - 1))) begin
			fl_cnt_reg <= '0;
		end else if (tick_reg) begin
			fl_cnt_reg <= fl_cnt_reg + 10'h1;
		end
	end

	// ----------------------------------------------------------------
	// Nonvolatile learning store
	// ----------------------------------------------------------------
	// Survives the power cycle: only the erase input clears it.
	logic [ID_W-1:0] hist_reg [MAX_LEARN+1];
	logic [3:0]      hist_n_reg;
	logic [ID_W-1:0] nv_id_reg;
	logic [ID_W-1:0] nv_cand_reg;
	logic            nv_valid_reg;
	logic            nv_pend_reg;
	logic [3:0]      left_reg;
	logic            fully_reg;
	gls_lr_t         lr_state;
	logic [TMR_W-1:0] lr_cnt_reg;
	logic [ID_W-1:0] cand_reg;

	function automatic logic in_hist(input logic [ID_W-1:0] id, input logic [3:0] n);
		logic hit;
		hit = 1'b0;
		for (int k = 0; k <= MAX_LEARN; k++) begin
			if (4'(k) < n && hist_reg[k] == id) begin
				hit = 1'b1;
			end
		end
		return hit;
	endfunction : in_hist

	logic id_match;
	logic learn_first;
	logic learn_ok;
	assign id_match    = i_act_present && nv_valid_reg && i_act_id == nv_id_reg;
	assign learn_first = i_act_present && !nv_valid_reg && lr_state == LR_IDLE;
	assign learn_ok    = fully_reg && i_act_single && left_reg != 4'h0
		&& !in_hist(i_act_id, hist_n_reg);

	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			fully_reg <= i_fully_coded;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_nv_clear) begin
			nv_valid_reg <= 1'b0;
			nv_pend_reg  <= 1'b0;
			hist_n_reg   <= 4'h0;
			left_reg     <= 4'(MAX_LEARN);
		end else if (i_reset) begin
			if (nv_pend_reg) begin
				nv_id_reg             <= nv_cand_reg;
				left_reg              <= left_reg - 4'h1;
				hist_reg[hist_n_reg]  <= nv_cand_reg;
				hist_n_reg            <= hist_n_reg + 4'h1;
				nv_pend_reg           <= 1'b0;
			end
		end else begin
			// Pending only while the confirmation window is open
			nv_pend_reg <= lr_state == LR_FAST;
			if (lr_state == LR_SLOW) begin
				nv_cand_reg <= cand_reg;
			end
			if (learn_first) begin
				nv_id_reg            <= i_act_id;
				nv_valid_reg         <= 1'b1;
				hist_reg[hist_n_reg] <= i_act_id;
				hist_n_reg           <= hist_n_reg + 4'h1;
			end
		end
	end

	// ----------------------------------------------------------------
	// Teach-in sequence
	// ----------------------------------------------------------------
	// Removing the actuator or swapping it mid-sequence abandons it.
	logic cand_gone;
	assign cand_gone = !i_act_present || i_act_id != cand_reg;

	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			lr_state   <= LR_IDLE;
			lr_cnt_reg <= '0;
			cand_reg   <= '0;
		end else begin
			case (lr_state)
				LR_IDLE: begin
					lr_cnt_reg <= '0;
					if (i_act_present && nv_valid_reg && !id_match && learn_ok) begin
						cand_reg <= i_act_id;
						lr_state <= LR_SLOW;
					end
				end
				LR_SLOW: begin
					if (cand_gone) begin
						lr_state <= LR_IDLE;
					end else if (tick_reg && lr_cnt_reg == TMR_W'(WAIT_TK - 1)) begin
						lr_cnt_reg <= '0;
						lr_state   <= LR_FAST;
					end else if (tick_reg) begin
						lr_cnt_reg <= lr_cnt_reg + 18'h1;
					end
				end
				LR_FAST: begin
					if (cand_gone || (tick_reg && lr_cnt_reg == TMR_W'(CONFIRM_TK - 1))) begin
						lr_state <= LR_IDLE;
					end else if (tick_reg) begin
						lr_cnt_reg <= lr_cnt_reg + 18'h1;
					end
				end
				default: lr_state <= LR_IDLE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Power-up holding force test
	// ----------------------------------------------------------------
	gls_ht_t          ht_state;
	logic [TMR_W-1:0] ht_cnt_reg;

	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			ht_state   <= HT_RUN;
			ht_cnt_reg <= '0;
		end else begin
			case (ht_state)
				HT_RUN: begin
					if (tick_reg && ht_cnt_reg == TMR_W'(HOLD_TEST_TICKS - 1)) begin
						ht_state <= i_hold_ok ? HT_PASS : HT_FAIL;
					end else if (tick_reg) begin
						ht_cnt_reg <= ht_cnt_reg + 18'h1;
					end
				end
				HT_PASS: ht_state <= HT_PASS;
				HT_FAIL: ht_state <= HT_FAIL;
				default: ht_state <= HT_FAIL;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Guard locking, faults and safety outputs
	// ----------------------------------------------------------------
	logic             mag_fault_reg;
	logic             forced_reg;
	logic             lock_err_reg;
	logic [TMR_W-1:0] low_cnt_reg;
	logic             relock_ok;
	logic             wind_bad;
	logic             magnet_next;
	logic             safe_next;
	logic             locked;

	assign wind_bad  = i_wind_open || i_wind_short;
	assign locked    = o_magnet_on && ht_state == HT_PASS;
	assign relock_ok = low_cnt_reg == TMR_W'(RELOCK_TICKS);
	assign magnet_next = ht_state == HT_RUN || (i_lock_request_input && id_match
		&& ht_state == HT_PASS && !lock_err_reg && !forced_reg && !mag_fault_reg && !i_supply_low);
	assign safe_next = magnet_next && ht_state == HT_PASS && !wind_bad;

	// Lock and forced-opening errors clear only after a long enough low phase of the request, or at reset
	always_ff @(posedge i_sys_clk) begin
		if (i_reset || i_lock_request_input) begin
			low_cnt_reg <= '0;
		end else if (tick_reg && !relock_ok) begin
			low_cnt_reg <= low_cnt_reg + 18'h1;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			mag_fault_reg <= 1'b0;
		end else if (o_magnet_on && wind_bad) begin
			mag_fault_reg <= 1'b1;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			forced_reg   <= 1'b0;
			lock_err_reg <= 1'b0;
		end else begin
			if (locked && !i_act_present) begin
				forced_reg <= 1'b1;
			end else if (!i_lock_request_input && relock_ok) begin
				forced_reg <= 1'b0;
			end
			if (i_lock_request_input && ht_state != HT_RUN
				&& (!id_match || i_supply_low || ht_state == HT_FAIL || mag_fault_reg)) begin
				lock_err_reg <= 1'b1;
			end else if (!i_lock_request_input && relock_ok) begin
				lock_err_reg <= 1'b0;
			end
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			o_magnet_on  <= 1'b0;
			o_safe_out_1 <= 1'b0;
			o_safe_out_2 <= 1'b0;
		end else begin
			o_magnet_on  <= magnet_next;
			o_safe_out_1 <= safe_next;
			o_safe_out_2 <= safe_next;
		end
	end

	// ----------------------------------------------------------------
	// Indicators
	// ----------------------------------------------------------------
	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			o_lock_green    <= 1'b0;
			o_lock_red      <= 1'b0;
			o_gate_yellow   <= 1'b0;
			o_learn_refused <= 1'b0;
			o_learn_left    <= 4'h0;
		end else begin
			o_lock_green    <= locked;
			o_lock_red      <= lock_err_reg || forced_reg;
			o_learn_refused <= lr_state == LR_IDLE && i_act_present && nv_valid_reg
				&& !id_match && !learn_ok;
			o_learn_left    <= left_reg;
			case (lr_state)
				LR_SLOW: o_gate_yellow <= fl_cnt_reg < FL_W'(SLOW_PERIOD_MS / 2);
				LR_FAST: o_gate_yellow <= fl_cnt_reg % FL_W'(FAST_PERIOD_MS)
					< FL_W'(FAST_PERIOD_MS / 2);
				default: o_gate_yellow <= id_match;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	sequence req_dropped_s;
		!i_lock_request_input;
	endsequence

	out_pair_a: assert property (@(posedge i_sys_clk) disable iff (i_reset)
		o_safe_out_1 == o_safe_out_2) else $error("safety outputs differ");
	out_cause_a: assert property (@(posedge i_sys_clk) disable iff (i_reset)
		req_dropped_s |=> !o_safe_out_1) else $error("output high without request");
	magnet_lock_a: assert property (@(posedge i_sys_clk) disable iff (i_reset)
		(ht_state == HT_PASS && i_lock_request_input && id_match && !lock_err_reg && !forced_reg
		&& !mag_fault_reg && !i_supply_low) |=> o_magnet_on) else $error("magnet not energized");
	hold_gate_a: assert property (@(posedge i_sys_clk) disable iff (i_reset)
		o_safe_out_1 |-> $past(ht_state) == HT_PASS) else $error("output before hold test");
	wind_fault_a: assert property (@(posedge i_sys_clk) disable iff (i_reset)
		(o_magnet_on && wind_bad) |=> !o_safe_out_1 ##1 !o_safe_out_1) else $error("winding fault ignored");
	forced_open_a: assert property (@(posedge i_sys_clk) disable iff (i_reset)
		(locked && !i_act_present) |=> !o_safe_out_1 && !o_safe_out_2) else $error("forced opening ignored");
	lock_error_a: assert property (@(posedge i_sys_clk) disable iff (i_reset)
		(i_lock_request_input && i_supply_low && ht_state == HT_PASS) |=> ##1 o_lock_red)
		else $error("low supply not shown");
	fast_after_a: assert property (@(posedge i_sys_clk) disable iff (i_reset)
		(lr_state == LR_FAST && $past(lr_state) == LR_SLOW) |-> $past(lr_cnt_reg) == TMR_W'(WAIT_TK - 1))
		else $error("fast flash too early");
	unique_refuse_a: assert property (@(posedge i_sys_clk) disable iff (i_reset)
		!fully_reg |-> lr_state == LR_IDLE) else $error("unique variant learning");
	history_a: assert property (@(posedge i_sys_clk) disable iff (i_reset)
		(lr_state == LR_IDLE && in_hist(i_act_id, hist_n_reg)) |=> lr_state == LR_IDLE)
		else $error("relearning old actuator");
	commit_a: assert property (@(posedge i_sys_clk) disable iff (i_nv_clear)
		(i_reset && nv_pend_reg) |=> left_reg == $past(left_reg) - 4'h1) else $error("count not decremented");
endmodule : gls_ctrl

// ### core/gls_pkg.sv
// Constants for the gate lock safety output controller
package gls_pkg;
	// ----------------------------------------------------------------
	// Clock and time base
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 8;
	localparam int TICK_NS       = 1000000;
	localparam int TICK_CYCLES   = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int MS_PER_S      = 1000;
	// ----------------------------------------------------------------
	// Times in their own units, counts in 1 ms ticks
	// ----------------------------------------------------------------
	localparam int RELOCK_MS        = 500;
	localparam int LEARN_WAIT_S     = 20;
	localparam int CONFIRM_S        = 120;
	localparam int HOLD_TEST_MS     = 50;
	localparam int SLOW_PERIOD_MS   = 1000;
	localparam int FAST_PERIOD_MS   = 200;
	localparam int RELOCK_TICKS     = RELOCK_MS;
	localparam int LEARN_WAIT_TICKS = LEARN_WAIT_S * MS_PER_S;
	localparam int CONFIRM_TICKS    = CONFIRM_S * MS_PER_S;
	localparam int HOLD_TEST_TICKS  = HOLD_TEST_MS;
	// ----------------------------------------------------------------
	// Learning
	// ----------------------------------------------------------------
	localparam int MAX_LEARN = 8;
	localparam int ID_W      = 32;
	localparam int TMR_W     = 18;
	localparam int FL_W      = 10;
	// ----------------------------------------------------------------
	// States
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {HT_RUN, HT_PASS, HT_FAIL} gls_ht_t;
	typedef enum logic [1:0] {LR_IDLE, LR_SLOW, LR_FAST} gls_lr_t;
endpackage : gls_pkg

// ### verification/gls_eval_model.sv
// Two-channel evaluation device model that drives the lock request
`timescale 1ns/1ps
module gls_eval_model #(
	parameter int LOW_CYC = 2020
) (
	// Clock and user wish
	input  wire logic i_sys_clk,
	input  wire logic i_want_lock,
	// Safety channels from the switch
	input  wire logic i_safe_out_1,
	input  wire logic i_safe_out_2,
	// Lock request and channel check
	output logic      o_lock_request,
	output logic      o_chan_err
);
	int low_cnt;
	initial begin
		o_lock_request = 1'b0;
		o_chan_err     = 1'b0;
		low_cnt        = 0;
	end
	// ----------------------------------------------------------------
	// Request: never re-raised before the low time has run out
	// ----------------------------------------------------------------
	// The low time runs whether or not the user already wants the lock again
	always @(negedge i_sys_clk) begin
		if (i_want_lock && (low_cnt >= LOW_CYC || o_lock_request)) begin
			o_lock_request <= 1'b1;
			low_cnt        <= 0;
		end else begin
			o_lock_request <= 1'b0;
			if (low_cnt < LOW_CYC) low_cnt <= low_cnt + 1;
		end
	end
	// Both channels must agree, as a feasibility monitor would demand
	always @(posedge i_sys_clk) begin
		if (i_safe_out_1 !== i_safe_out_2) o_chan_err <= 1'b1;
	end
endmodule : gls_eval_model

// ### verification/test_gls_ctrl.sv
// Self-checking bench for the gate lock safety output controller
`timescale 1ns/1ps
module test_gls_ctrl;
	import gls_pkg::*;
	localparam int TK       = 4;
	localparam int HOLD_CYC = HOLD_TEST_TICKS * TK + 10;
	localparam int LOW_CYC  = RELOCK_TICKS * TK + 20;
	logic            i_sys_clk, i_reset, i_nv_clear, i_fully_coded, i_act_present, i_act_single;
	logic            i_hold_ok, i_wind_open, i_wind_short, i_supply_low, want, lock_req;
	logic            s1, s2, mag, green, red, yel, refused, chan_err;
	logic [ID_W-1:0] i_act_id;
	logic [3:0]      left;
	logic [3:0]      rows [3] = '{4'b1111, 4'b1000, 4'b1111};
	int              n_mismatch, check_count, cyc;
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin n_mismatch++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end

	gls_ctrl #(.TICK_CYC(TK), .WAIT_TK(5), .CONFIRM_TK(8)) dut (
		.i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_nv_clear(i_nv_clear), .i_fully_coded(i_fully_coded),
		.i_act_present(i_act_present), .i_act_id(i_act_id), .i_act_single(i_act_single),
		.i_lock_request_input(lock_req), .i_hold_ok(i_hold_ok), .i_wind_open(i_wind_open),
		.i_wind_short(i_wind_short), .i_supply_low(i_supply_low), .o_safe_out_1(s1), .o_safe_out_2(s2),
		.o_magnet_on(mag), .o_lock_green(green), .o_lock_red(red), .o_gate_yellow(yel),
		.o_learn_refused(refused), .o_learn_left(left));
	gls_eval_model #(.LOW_CYC(LOW_CYC)) eval (
		.i_sys_clk(i_sys_clk), .i_want_lock(want), .i_safe_out_1(s1), .i_safe_out_2(s2),
		.o_lock_request(lock_req), .o_chan_err(chan_err));

	initial begin
		i_sys_clk = 1'b0;
		forever #4 i_sys_clk = ~i_sys_clk;
	end
	// Hang guard, well above the sum of all relock waits
	always @(posedge i_sys_clk) begin
		cyc++;
		if (cyc == 30000) begin
			n_mismatch++;
			close_out();
		end
	end

	task close_out;
		$display("mismatches=%0d checks=%0d", n_mismatch, check_count);
		if (n_mismatch == 0 && check_count > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : close_out
	task cyc_n(input int n);
		repeat (n) @(negedge i_sys_clk);
	endtask : cyc_n
	// Power cycle: two reset edges, then the holding test runs out
	task pwr(input logic fc);
		i_fully_coded = fc;
		i_reset       = 1'b1;
		cyc_n(2);
		`CHK(s1, 1'b0)
		i_reset = 1'b0;
		cyc_n(HOLD_CYC);
	endtask : pwr
	task req(input logic w);
		want = w;
		for (int k = 0; k < LOW_CYC + 10 && lock_req !== w; k++) cyc_n(1);
		cyc_n(3);
	endtask : req
	task expect_out(input logic e);
		`CHK(s1, e)
		`CHK(s2, e)
	endtask : expect_out

	initial begin
		{i_reset, i_nv_clear, i_fully_coded, i_act_single, i_hold_ok} = 5'h1F;
		{i_act_present, i_wind_open, i_wind_short, i_supply_low, want} = 5'h00;
		i_act_id = 32'h0000_0A0A;
		cyc_n(2);
		i_nv_clear = 1'b0;
		i_reset    = 1'b0;
		cyc_n(3);
		`CHK(left, 4'h8)
		cyc_n(HOLD_CYC);
		i_act_present = 1'b1;
		cyc_n(2);
		`CHK(refused, 1'b0)
		`CHK(yel, 1'b1)
		// ----------------------------------------------------------------
		// Table of plain cases: present, request, safe out, magnet
		// ----------------------------------------------------------------
		for (int i = 0; i < 3; i++) begin
			i_act_present = rows[i][3];
			req(rows[i][2]);
			expect_out(rows[i][1]);
			`CHK(mag, rows[i][0])
		end
		`CHK(green, 1'b1)
		// Winding faults latch until the next power cycle
		for (int k = 0; k < 2; k++) begin
			{i_wind_open, i_wind_short} = k[0] ? 2'b01 : 2'b10;
			cyc_n(1);
			{i_wind_open, i_wind_short} = 2'b00;
			cyc_n(20);
			expect_out(1'b0);
			pwr(1'b1);
			expect_out(1'b1);
		end
		// Forced opening while locked
		i_act_present = 1'b0;
		cyc_n(3);
		expect_out(1'b0);
		`CHK(red, 1'b1)
		i_act_present = 1'b1;
		cyc_n(5);
		expect_out(1'b0);
		req(1'b0);
		req(1'b1);
		expect_out(1'b1);
		// Supply too low to pull the magnet
		i_supply_low = 1'b1;
		cyc_n(3);
		`CHK(red, 1'b1)
		`CHK(mag, 1'b0)
		expect_out(1'b0);
		i_supply_low = 1'b0;
		req(1'b0);
		req(1'b1);
		// Holding test failing at power-up
		i_hold_ok = 1'b0;
		pwr(1'b1);
		expect_out(1'b0);
		`CHK(green, 1'b0)
		i_hold_ok = 1'b1;
		req(1'b0);
		pwr(1'b1);
		// Teach-in: actuator stays in range up to the power cycle
		i_act_id = 32'h0000_0B0B;
		cyc_n(4);
		`CHK(refused, 1'b0)
		`CHK(yel, 1'b1)
		cyc_n(5 * TK + 8);
		pwr(1'b1);
		`CHK(left, 4'h7)
		req(1'b1);
		expect_out(1'b1);
		req(1'b0);
		i_act_id = 32'h0000_0A0A;
		cyc_n(4);
		`CHK(refused, 1'b1)
		// Window runs out with no power cycle
		i_act_id = 32'h0000_0C0C;
		cyc_n(2);
		// A second transponder keeps the expired sequence from restarting
		i_act_single = 1'b0;
		cyc_n((5 + 8) * TK + 20);
		`CHK(refused, 1'b1)
		pwr(1'b1);
		`CHK(left, 4'h7)
		i_act_single = 1'b1;
		i_act_id     = 32'h0000_0B0B;
		req(1'b1);
		expect_out(1'b1);
		// Uniquely coded strap refuses a second actuator
		req(1'b0);
		pwr(1'b0);
		i_act_id = 32'h0000_0D0D;
		cyc_n(4);
		`CHK(refused, 1'b1)
		`CHK(chan_err, 1'b0)
		close_out();
	end
endmodule : test_gls_ctrl
